// [servo_pulse_io.v]
// Function
// - the command decoder takes pulse-and-direction, forward/reverse or quadrature, by setting.
// - quadrature input counts every edge of both phases, four counts per cycle.
// - feedback gives two phases a quarter period apart, the leader showing direction.
// - feedback pulses per revolution are settable from 16 to 262144.
// - feedback rate follows shaft speed on average; each encoder count releases its edges on consecutive clocks.
// - a per-revolution setting of zero selects the numerator/denominator division ratio.
// - one marker pulse per motor revolution on the differential marker output.
// - in per-revolution mode the marker is aligned with phase A and lasts one quadrature state, half of the phase-A high time.
// - in division mode the marker stays active for at least 125 us.
// - in per-revolution mode a setting selects how the marker lines up with the phases.
// - the single-ended marker copies the differential marker.
// - each sequence input except an interrupt input passes a 0.5 ms two-scan filter.
// - eight sequence inputs and five sequence outputs are provided.
`default_nettype none
`include "servo_io_defines.vh"
module servo_pulse_io
(
    input  wire        clk_sys,                       // 100 MHz system clock
    input  wire        reset,                         // synchronous, active high
    input  wire [1:0]  cmd_format,                    // command pulse format
    input  wire        cmd_pulse_a,                   // command line a (pin)
    input  wire        cmd_pulse_b,                   // command line b (pin)
    output reg         cmd_step,                      // one-cycle count pulse
    output reg         cmd_dir_up,                    // direction of cmd_step
    output reg  [31:0] cmd_position,                  // accumulated command count
    input  wire [15:0] enc_counts_per_rev,            // encoder counts per revolution
    input  wire        enc_step,                      // one encoder count, same clock
    input  wire        enc_dir_up,                    // direction of enc_step
    input  wire [18:0] pulses_per_rev_setting,        // 0 or 16..262144
    input  wire [15:0] division_numerator_setting,    // ratio numerator
    input  wire [15:0] division_denominator_setting,  // ratio denominator
    input  wire        marker_align,                  // marker phase relation
    output reg         feedback_phase_a,              // feedback phase a
    output reg         feedback_phase_b,              // feedback phase b
    output reg         feedback_marker,               // once-per-rev marker
    output reg         marker_single_ended,           // open collector marker copy
    input  wire [7:0]  seq_in,                        // sequence inputs 1..8 (pins)
    input  wire [7:0]  seq_irq_select,                // inputs used as interrupts
    output reg  [7:0]  seq_in_filtered,               // filtered sequence inputs
    input  wire [4:0]  seq_out_request,               // status to drive out
    output reg  [4:0]  seq_out                        // sequence outputs 1..5
);
    localparam [15:0] SCAN_CYCLES   = `SEQ_SCAN_CYCLES;
    localparam [15:0] MARKER_CYCLES = `MARKER_MIN_CYCLES;

    // pin synchronisers, two flops each
    reg [1:0] a_s1, a_s2;
    reg [7:0] seq_s1, seq_s2;
    reg [1:0] ab_prev;
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            a_s1    <= 2'h0;
            a_s2    <= 2'h0;
            ab_prev <= 2'h0;
            seq_s1  <= 8'h00;
            seq_s2  <= 8'h00;
        end
        else
        begin
            a_s1    <= {cmd_pulse_b, cmd_pulse_a};
            a_s2    <= a_s1;
            ab_prev <= a_s2;
            seq_s1  <= seq_in;
            seq_s2  <= seq_s1;
        end
    end

    // command decoder; 10 ns sampling covers the 1 MHz host limit
    wire a_rise = a_s2[0] & ~ab_prev[0];
    wire b_rise = a_s2[1] & ~ab_prev[1];
    wire a_chg  = a_s2[0] ^ ab_prev[0];
    wire b_chg  = a_s2[1] ^ ab_prev[1];
    reg  next_step;
    reg  next_up;
    always @*
    begin
        next_step = 1'b0;
        next_up   = 1'b1;
        case (cmd_format)
            `FMT_PULSE_DIR:
            begin
                next_step = a_rise;
                next_up   = a_s2[1];
            end
            `FMT_FWD_REV:
            begin
                next_step = a_rise ^ b_rise;
                next_up   = a_rise;
            end
            `FMT_QUAD:
            begin
                // every edge of either phase counts, x4
                next_step = a_chg ^ b_chg;
                next_up   = a_s2[0] ^ ab_prev[1];
            end
            default:
            begin
                next_step = 1'b0;
                next_up   = 1'b1;
            end
        endcase
    end

    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            cmd_step     <= 1'b0;
            cmd_dir_up   <= 1'b1;
            cmd_position <= 32'h00000000;
        end
        else
        begin
            cmd_step   <= next_step;
            cmd_dir_up <= next_up;
            if (next_step)
                cmd_position <= next_up ? cmd_position + 32'h00000001
                                        : cmd_position - 32'h00000001;
        end
    end

    // rate mode: pulses per rev, or division ratio when setting is zero
    wire        ratio_mode = (pulses_per_rev_setting == 19'h00000);
    wire [18:0] ppr_clamped =
        (pulses_per_rev_setting < `PPR_MIN) ? `PPR_MIN :
        (pulses_per_rev_setting > `PPR_MAX) ? `PPR_MAX :
        pulses_per_rev_setting;
    // output edges per rev = 4 * ppr; in ratio mode counts*num/den
    wire [20:0] add_ppr   = {ppr_clamped, 2'h0};
    wire [20:0] add_ratio = {5'h00, division_numerator_setting};
    wire [20:0] acc_add   = ratio_mode ? add_ratio : add_ppr;
    wire [20:0] acc_mod   = ratio_mode ? {5'h00, division_denominator_setting}
                                       : {5'h00, enc_counts_per_rev};

    // a fractional accumulator releases output edges one per clock while it holds a whole modulus
    // each encoder count adds its share; every whole modulus drains as one edge
    // limitation: a large ratio with a small modulus can outrun the 22-bit store
    reg [21:0] frac_acc;
    reg [15:0] rev_count;
    reg [1:0]  quad_state;
    reg        pend_up;
    reg        rev_mark;
    wire [21:0] acc_sum = frac_acc + {1'b0, acc_add};
    wire        emit    = (acc_mod != 21'h000000) && !enc_step &&
                          (frac_acc >= {1'b0, acc_mod});
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            frac_acc  <= 22'h000000;
            rev_count <= 16'h0000;
            pend_up   <= 1'b1;
            rev_mark  <= 1'b0;
        end
        else
        begin
            rev_mark <= 1'b0;
            if (enc_step)
            begin
                pend_up <= enc_dir_up;
                // one marker event per revolution of the encoder
                if (enc_dir_up)
                begin
                    if (rev_count == enc_counts_per_rev - 16'h0001)
                    begin
                        rev_count <= 16'h0000;
                        rev_mark  <= 1'b1;
                    end
                    else
                        rev_count <= rev_count + 16'h0001;
                end
                else
                begin
                    if (rev_count == 16'h0000)
                    begin
                        rev_count <= enc_counts_per_rev - 16'h0001;
                        rev_mark  <= 1'b1;
                    end
                    else
                        rev_count <= rev_count - 16'h0001;
                end
                if (acc_mod == 21'h000000)
                    frac_acc <= 22'h000000;
                else
                    frac_acc <= acc_sum;
            end
            else if (emit)
                frac_acc <= frac_acc - {1'b0, acc_mod};
        end
    end

    // quadrature output: one gray step per emitted edge
    // output speed limit is left to the integrator's settings
    always @(posedge clk_sys)
    begin
        if (reset)
            quad_state <= 2'h0;
        else if (emit)
            quad_state <= pend_up ? quad_state + 2'h1 : quad_state - 2'h1;
    end

    // marker generation
    reg        mark_arm;
    reg [15:0] mark_timer;
    reg        next_marker;
    wire       marker_phase = (marker_align == `MARKER_ON_A_HIGH) ?
                              (quad_state == 2'h1) : (quad_state == 2'h2);
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            mark_arm    <= 1'b0;
            mark_timer  <= 16'h0000;
            next_marker <= 1'b0;
        end
        else if (ratio_mode)
        begin
            // not tied to phase a, held at least the minimum width
            mark_arm <= 1'b0;
            if (rev_mark)
                mark_timer <= MARKER_CYCLES;
            else if (mark_timer != 16'h0000)
                mark_timer <= mark_timer - 16'h0001;
            next_marker <= rev_mark || (mark_timer > 16'h0001);
        end
        else
        begin
            // wait for the selected quadrature state and hold while that state lasts
            mark_timer <= 16'h0000;
            if (rev_mark)
                mark_arm <= 1'b1;
            else if (mark_arm && marker_phase)
                mark_arm <= 1'b0;
            if (mark_arm && marker_phase)
                next_marker <= 1'b1;
            else if (!marker_phase)
                next_marker <= 1'b0;
        end
    end

    // registered outputs; single-ended copy matches the differential marker
    // phases pass two flops so they line up with the marker's extra stage
    reg phase_a_d;
    reg phase_b_d;
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            phase_a_d           <= 1'b0;
            phase_b_d           <= 1'b0;
            feedback_phase_a    <= 1'b0;
            feedback_phase_b    <= 1'b0;
            feedback_marker     <= 1'b0;
            marker_single_ended <= 1'b0;
            seq_out             <= 5'h00;
        end
        else
        begin
            phase_a_d           <= quad_state[1] ^ quad_state[0];
            phase_b_d           <= quad_state[1];
            feedback_phase_a    <= phase_a_d;
            feedback_phase_b    <= phase_b_d;
            feedback_marker     <= next_marker;
            marker_single_ended <= next_marker;
            seq_out             <= seq_out_request;
        end
    end

    // scan tick every 0.5 ms for the input filter
    reg [15:0] scan_cnt;
    reg        scan_tick;
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            scan_cnt  <= 16'h0000;
            scan_tick <= 1'b0;
        end
        else if (scan_cnt == SCAN_CYCLES - 16'h0001)
        begin
            scan_cnt  <= 16'h0000;
            scan_tick <= 1'b1;
        end
        else
        begin
            scan_cnt  <= scan_cnt + 16'h0001;
            scan_tick <= 1'b0;
        end
    end

    wire [7:0] filt;
    seq_input_filter u_filter
    (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .scan_tick(scan_tick),
        .raw_in   (seq_s2),
        .bypass   (seq_irq_select),
        .filtered (filt)
    );

    always @(posedge clk_sys)
    begin
        if (reset)
            seq_in_filtered <= 8'h00;
        else
            seq_in_filtered <= filt;
    end
endmodule
`default_nettype wire

// [servo_io_defines.vh]
`ifndef SERVO_IO_DEFINES_VH
`define SERVO_IO_DEFINES_VH
// command input formats
`define FMT_PULSE_DIR       2'h0
`define FMT_FWD_REV         2'h1
`define FMT_QUAD            2'h2
// feedback pulses per revolution range
`define PPR_MIN             19'h00010
`define PPR_MAX             19'h40000
// marker alignment select
`define MARKER_ON_A_HIGH    1'h0
`define MARKER_ON_B_HIGH    1'h1
// sequence input filter: 0.5 ms scan at 100 MHz
`define CLK_MHZ             100
`define SEQ_FILTER_US_X10   5
`define SEQ_SCAN_CYCLES     ((`SEQ_FILTER_US_X10 * 100 * `CLK_MHZ) / 1)
// marker minimum width in division mode: 125 us
`define MARKER_MIN_US       125
`define MARKER_MIN_CYCLES   (`MARKER_MIN_US * `CLK_MHZ)
`define SEQ_IN_COUNT        8
`define SEQ_OUT_COUNT       5
`endif

// [seq_input_filter.v]
`default_nettype none
// two-scan agreement filter for the sequence inputs
module seq_input_filter
(
    input  wire       clk_sys,     // system clock
    input  wire       reset,       // synchronous reset
    input  wire       scan_tick,   // one pulse per scan period
    input  wire [7:0] raw_in,      // synchronised inputs
    input  wire [7:0] bypass,      // 1 = interrupt input, no filter
    output reg  [7:0] filtered     // accepted levels
);
    reg [7:0] scan_prev;
    genvar i;

    // a new level is taken only when two consecutive scans agree, or at once on every clock for a bypassed input
    generate
        for (i = 0; i < 8; i = i + 1)
        begin : g_bit
            always @(posedge clk_sys)
            begin
                if (reset)
                begin
                    scan_prev[i] <= 1'b0;
                    filtered[i]  <= 1'b0;
                end
                else if (bypass[i])
                begin
                    scan_prev[i] <= raw_in[i];
                    filtered[i]  <= raw_in[i];
                end
                else if (scan_tick)
                begin
                    scan_prev[i] <= raw_in[i];
                    if (scan_prev[i] == raw_in[i])
                        filtered[i] <= raw_in[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// [host_cmd_model.sv]
`default_nettype none
// host controller model driving the two command pulse lines
module host_cmd
(
    input  wire logic       clk_sys,  // system clock
    input  wire logic [1:0] fmt,      // command format in use
    output logic            a,        // command line a
    output logic            b         // command line b
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        a = 1'b0;
        b = 1'b0;
    end
    // one unit per 100 cycles keeps the host at 1 MHz, well above the 2-cycle width
    task automatic burst(input logic up, input int n);
        repeat (n)
        begin
            if (fmt == 2'h2)
            begin
                // gray order, a leads b when counting up
                for (int q = 0; q < 4; q++)
                begin
                    repeat (25) @(negedge clk_sys);
                    if (q[0] == !up)
                        a = ~a;
                    else
                        b = ~b;
                end
            end
            else
            begin
                if (fmt == 2'h0)
                    b = up;
                repeat (50) @(negedge clk_sys);
                if (fmt == 2'h1 && !up)
                    b = 1'b1;
                else
                    a = 1'b1;
                repeat (50) @(negedge clk_sys);
                a = 1'b0;
                if (fmt == 2'h1)
                    b = 1'b0;
            end
        end
    endtask
endmodule
`default_nettype wire

// [servo_pulse_io_asserts.sv]
`default_nettype none
// port-level checks for the command decoder and feedback generator
module servo_pulse_io_chk
(
    input wire logic        clk_sys,                 // system clock
    input wire logic        reset,                   // synchronous reset
    input wire logic [1:0]  cmd_format,              // command format
    input wire logic        cmd_step,                // count pulse
    input wire logic        cmd_dir_up,              // count direction
    input wire logic [31:0] cmd_position,            // command count
    input wire logic [18:0] pulses_per_rev_setting,  // 0 selects ratio mode
    input wire logic        feedback_phase_a,        // phase a
    input wire logic        feedback_phase_b,        // phase b
    input wire logic        feedback_marker,         // marker
    input wire logic        marker_single_ended,     // marker copy
    input wire logic [4:0]  seq_out_request,         // output request
    input wire logic [4:0]  seq_out                  // sequence outputs
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MK_MIN = 12500;
    logic [15:0] mk_len;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // length of the marker so far; a counter avoids unrolling 12500 cycles
    always_ff @(posedge clk_sys)
        mk_len <= (reset || !feedback_marker) ? 16'h0000 : mk_len + 16'h0001;
    property p_se; marker_single_ended == feedback_marker; endproperty
    a_se: assert property (p_se) else $error("marker copy differs");
    property p_fmt; cmd_format == 2'h3 |-> !cmd_step; endproperty
    a_fmt: assert property (p_fmt) else $error("step with no format");
    property p_up; cmd_step && cmd_dir_up |-> cmd_position == $past(cmd_position) + 32'h1; endproperty
    a_up: assert property (p_up) else $error("up step not added");
    property p_dn; cmd_step && !cmd_dir_up |-> cmd_position == $past(cmd_position) - 32'h1; endproperty
    a_dn: assert property (p_dn) else $error("down step not taken");
    property p_pos; !cmd_step |-> $stable(cmd_position); endproperty
    a_pos: assert property (p_pos) else $error("count moved without step");
    property p_quad; $changed(feedback_phase_a) |-> $stable(feedback_phase_b); endproperty
    a_quad: assert property (p_quad) else $error("both phases moved");
    property p_align; pulses_per_rev_setting != 19'h0 && feedback_marker |-> feedback_phase_a; endproperty
    a_align: assert property (p_align) else $error("marker off phase a");
    property p_wide; $fell(feedback_marker) && pulses_per_rev_setting == 19'h0 |-> mk_len >= MK_MIN; endproperty
    a_wide: assert property (p_wide) else $error("ratio marker too short");
    property p_out; !$past(reset) |-> seq_out == $past(seq_out_request); endproperty
    a_out: assert property (p_out) else $error("output not one cycle behind");
endmodule
bind servo_pulse_io servo_pulse_io_chk i_chk (.clk_sys(clk_sys), .reset(reset),
    .cmd_format(cmd_format), .cmd_step(cmd_step), .cmd_dir_up(cmd_dir_up),
    .cmd_position(cmd_position), .pulses_per_rev_setting(pulses_per_rev_setting),
    .feedback_phase_a(feedback_phase_a), .feedback_phase_b(feedback_phase_b),
    .feedback_marker(feedback_marker), .marker_single_ended(marker_single_ended),
    .seq_out_request(seq_out_request), .seq_out(seq_out));
`default_nettype wire

// [test_servo_pulse_io.sv]
`default_nettype none
module test_servo_pulse_io;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, reset, cmd_pulse_a, cmd_pulse_b, enc_step, enc_dir_up, marker_align;
    logic        cmd_step, cmd_dir_up, feedback_phase_a, feedback_phase_b;
    logic        feedback_marker, marker_single_ended, pa_q, mk_q, b_last;
    logic [1:0]  cmd_format;
    logic [4:0]  seq_out_request, seq_out;
    logic [7:0]  seq_in, seq_irq_select, seq_in_filtered;
    logic [15:0] enc_counts_per_rev, division_numerator_setting, division_denominator_setting;
    logic [18:0] pulses_per_rev_setting;
    logic [31:0] cmd_position;
    int          n_fail = 0, total_checks = 0, n_step = 0, n_rise = 0, n_mark = 0, mk_w = 0;

    servo_pulse_io i_dut (.clk_sys(clk_sys), .reset(reset), .cmd_format(cmd_format),
        .cmd_pulse_a(cmd_pulse_a), .cmd_pulse_b(cmd_pulse_b), .cmd_step(cmd_step),
        .cmd_dir_up(cmd_dir_up), .cmd_position(cmd_position),
        .enc_counts_per_rev(enc_counts_per_rev), .enc_step(enc_step), .enc_dir_up(enc_dir_up),
        .pulses_per_rev_setting(pulses_per_rev_setting),
        .division_numerator_setting(division_numerator_setting),
        .division_denominator_setting(division_denominator_setting),
        .marker_align(marker_align), .feedback_phase_a(feedback_phase_a),
        .feedback_phase_b(feedback_phase_b), .feedback_marker(feedback_marker),
        .marker_single_ended(marker_single_ended), .seq_in(seq_in),
        .seq_irq_select(seq_irq_select), .seq_in_filtered(seq_in_filtered),
        .seq_out_request(seq_out_request), .seq_out(seq_out));
    host_cmd i_host (.clk_sys(clk_sys), .fmt(cmd_format), .a(cmd_pulse_a), .b(cmd_pulse_b));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // tally events at the falling edge, where the outputs have settled
    always @(negedge clk_sys)
    begin
        if (cmd_step === 1'b1) n_step++;
        if (feedback_phase_a === 1'b1 && pa_q === 1'b0)
        begin
            n_rise++;
            b_last = feedback_phase_b;
        end
        if (feedback_marker === 1'b1) mk_w = (mk_q === 1'b1) ? mk_w + 1 : 1;
        if (feedback_marker === 1'b1 && mk_q !== 1'b1) n_mark++;
        pa_q = feedback_phase_a;
        mk_q = feedback_marker;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t ns: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic run_cmd(input logic [1:0] f, input logic up, input int n, input int exp);
        logic [31:0] p0;
        cmd_format = f;
        p0 = cmd_position;
        n_step = 0;
        i_host.burst(up, n);
        repeat (10) @(negedge clk_sys);
        chk(n_step, exp);
        chk(cmd_position - p0, up ? exp : -exp);
    endtask
    // a long gap between encoder counts lets queued feedback edges drain
    task automatic enc(input logic up, input int n);
        repeat (n)
        begin
            enc_dir_up = up;
            enc_step = 1'b1;
            @(negedge clk_sys);
            enc_step = 1'b0;
            repeat (200) @(negedge clk_sys); // slow counts keep feedback edges sparse
        end
    endtask

    // every format; direction line set before the pulse; format 3 counts nothing
    task automatic t_cmd();
        run_cmd(2'h0, 1'b1, 3, 3);
        run_cmd(2'h0, 1'b0, 2, 2);
        run_cmd(2'h1, 1'b1, 2, 2);
        run_cmd(2'h1, 1'b0, 3, 3);
        run_cmd(2'h2, 1'b1, 2, 8);
        run_cmd(2'h2, 1'b0, 1, 4);
        run_cmd(2'h3, 1'b1, 2, 0);
        $display("command formats done");
    endtask
    // one revolution each way at the lowest count and double it, both alignments
    task automatic t_feedback();
        logic bu;
        enc_counts_per_rev = 16'h0010;
        for (int i = 0; i < 2; i++)
        begin
            pulses_per_rev_setting = 19'h00010 << i;
            marker_align = i[0];
            n_rise = 0;
            n_mark = 0;
            enc(1'b1, 16);
            chk(n_rise, 16 << i);
            chk(n_mark, 1);
            bu = b_last;
            enc(1'b0, 16);
            chk(b_last ^ bu, 1);
        end
        $display("feedback per revolution done");
    endtask
    task automatic t_ratio();
        pulses_per_rev_setting = 19'h00000;
        division_numerator_setting = 16'h0001;
        division_denominator_setting = 16'h0004;
        n_mark = 0;
        n_rise = 0;
        enc(1'b1, 16);
        repeat (13000) @(negedge clk_sys);
        chk(n_rise != 0, 1);
        chk(n_mark, 1);
        chk(mk_w >= 12500, 1);
        $display("feedback ratio done");
    endtask
    task automatic t_seq();
        int t;
        seq_irq_select = 8'h01;
        seq_in = 8'h03;
        seq_out_request = 5'h15;
        repeat (10) @(negedge clk_sys);
        chk(seq_in_filtered, 8'h01);
        chk(seq_out, 5'h15);
        t = 0;
        while (seq_in_filtered[1] !== 1'b1)
        begin
            t++;
            if (t > 110000)
            begin
                n_fail++;
                conclude();
            end
            @(negedge clk_sys);
        end
        chk(t > 49000, 1);
        $display("sequence inputs done");
    endtask

    initial
    begin
        reset = 1'b1;
        cmd_format = 2'h0;
        enc_step = 1'b0;
        enc_dir_up = 1'b1;
        enc_counts_per_rev = 16'h0010;
        pulses_per_rev_setting = 19'h00010;
        division_numerator_setting = 16'h0001;
        division_denominator_setting = 16'h0004;
        marker_align = 1'b0;
        seq_in = 8'h00;
        seq_irq_select = 8'h00;
        seq_out_request = 5'h00;
        repeat (3) @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        t_cmd();
        t_feedback();
        t_ratio();
        t_seq();
        conclude();
    end
endmodule
`default_nettype wire
